// >>> audio_port_cfg.svh
/*
  Register offsets, field positions, reset values and fixed patterns of the
  audio port slot and sense framing block.
  Assumes it is included by its bare name after the include path is set.
*/
`ifndef AUDIO_PORT_CFG_SVH
`define AUDIO_PORT_CFG_SVH

// Register offsets on the plain register port.
`define ADDR_TDM_CTRL 8'h0C
`define ADDR_PORT_CTRL1 8'h0D
`define ADDR_PORT_CTRL2 8'h0E
`define ADDR_LEFT_SLOT 8'h0F
`define ADDR_RIGHT_SLOT 8'h10
`define ADDR_RESULT_LOW 8'h20
`define ADDR_RESULT_HIGH 8'h21
`define ADDR_SENSE_CTRL 8'h28
`define ADDR_GAIN_CTRL 8'h30
`define ADDR_GAIN_STATUS 8'h31

// Field positions.
`define BIT_OFFSET_MODE 14
`define BIT_ALT_FRAME 8
`define BIT_CHANNEL_SWAP 5
`define BIT_WLEN_HI 3
`define BIT_WLEN_LO 2
`define BIT_SLOT_ENABLE 10
`define BIT_PULL_ENABLE 6
`define BIT_PULL_SELECT 5
`define BIT_TRISTATE_CTL 4
`define BIT_NORMAL_AUDIO 15
`define BIT_SENSE_UNSIGNED 7
`define BIT_GAIN_POSITION 0

// Reset values.
`define RST_TDM_CTRL 16'h0000
`define RST_PORT_CTRL1 16'h0000
`define RST_PORT_CTRL2 16'h0040
`define RST_SLOT_DELAY 10'h000
`define RST_SENSE_CTRL 16'h0000
`define RST_GAIN_CTRL 16'h0000

// Fixed patterns and counts.
`define SENSE_PREAMBLE 4'hA
`define TYPE_JUNCTION 4'h0
`define TYPE_AMBIENT 4'h1
`define TYPE_BATTERY 4'h3
`define GAIN_BITS 8
`define POS_IDLE 11'h7FF

`endif

// >>> audio_port_pkg.sv
/*
  Types shared by the audio port slot and sense framing block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package audio_port_pkg;

  // Port word length code as held in the port control register.
  typedef enum logic [1:0] {
    WLEN_16 = 2'b00,
    WLEN_20 = 2'b01,
    WLEN_24 = 2'b10,
    WLEN_32 = 2'b11
  } word_len_t;

  // Placement of the two channels inside the frame.
  typedef enum logic [1:0] {
    PLACE_PLAIN = 2'b00,
    PLACE_SLOT = 2'b01,
    PLACE_OFFSET = 2'b11
  } placement_t;

endpackage

`default_nettype wire

// >>> pin_sync.sv
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes each bit is an independent level from outside the core clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk, // Core clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] async_in, // Levels from pins.
  output logic [WIDTH-1:0] sync_out // Levels on the core clock.
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// >>> audio_port_framing.sv
/*
  Serial audio port framing: slot and offset placement of the two capture
  channels, idle behaviour of the capture output, sense word layout, and the
  stereo gain exchange on the general pin.
  Assumes a slave port: bit clock and frame sync come from outside and are
  sampled by core_clk, which must run several times faster than the bit clock.
  Sense, converter and gain inputs come from logic on core_clk.
*/
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "audio_port_cfg.svh"

module audio_port_framing
  import audio_port_pkg::*;
#(
  parameter int DELAY_W = 10
) (
  input wire logic core_clk, // Core clock, 125 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [15:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  output logic [15:0] reg_rdata, // Read data, one cycle after the strobe.
  input wire logic bclk_pin, // Bit clock from the host.
  input wire logic fs_pin, // Frame sync from the host.
  input wire logic playback_serial_in, // Serial data into the device.
  output logic capture_serial_out, // Serial data out of the device.
  output logic capture_serial_oe, // High while the device drives the output.
  output logic capture_pull_up, // Weak pull-up request for the idle output.
  output logic capture_pull_down, // Weak pull-down request for the idle output.
  input wire logic gain_share_pin_in, // General pin level.
  output logic gain_share_pin_out, // General pin drive value.
  output logic gain_share_pin_oe, // High while the device drives the pin.
  input wire logic [31:0] audio_left, // Normal audio word, left aligned.
  input wire logic [31:0] audio_right, // Normal audio word, left aligned.
  input wire logic [15:0] voltage_sense, // Voltage sense sample.
  input wire logic [15:0] current_sense, // Current sense sample.
  input wire logic [3:0] converter_type, // Type code of the current message.
  input wire logic [7:0] junction_temperature, // Converter result 0.
  input wire logic [7:0] ambient_temperature, // Converter result 1.
  input wire logic [7:0] battery_voltage, // Converter result 2.
  input wire logic [7:0] own_gain, // Gain in use by this device.
  output logic [7:0] partner_gain, // Gain received from the partner.
  output logic [31:0] playback_word // Left playback word, right aligned.
);

  // Refuse slot field widths outside 1 to 10 bits.
  generate
    if (DELAY_W < 1 || DELAY_W > 10) begin : g_bad_width
      $error("DELAY_W must lie between 1 and 10");
    end
  endgenerate

  logic [15:0] tdm_reg;
  logic [15:0] ctrl1_reg;
  logic [15:0] ctrl2_reg;
  logic [DELAY_W-1:0] left_delay_reg;
  logic [DELAY_W-1:0] right_delay_reg;
  logic [15:0] sense_reg;
  logic [15:0] gain_ctl_reg;
  logic [3:0] sync_bits;
  logic bclk_s;
  logic fs_s;
  logic pb_s;
  logic gin_s;
  logic bclk_d_reg;
  logic fs_q_reg;
  logic [10:0] pos_reg;
  logic [31:0] left_word_reg;
  logic [31:0] right_word_reg;
  logic last_bit_reg;
  logic [31:0] pb_shift_reg;
  logic [3:0] gcnt_reg;
  logic gact_reg;
  logic [7:0] grx_reg;

  // Pins pass two flops before anything reads them.
  pin_sync #(
    .WIDTH(4)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({bclk_pin, fs_pin, playback_serial_in, gain_share_pin_in}),
    .sync_out(sync_bits)
  );

  assign bclk_s = sync_bits[3];
  assign fs_s = sync_bits[2];
  assign pb_s = sync_bits[1];
  assign gin_s = sync_bits[0];

  // Bit clock edges and frame sync edges seen at the rising bit-clock edge.
  wire bclk_rise = bclk_s & ~bclk_d_reg;
  wire bclk_fall = ~bclk_s & bclk_d_reg;
  wire fs_rise = bclk_rise & fs_s & ~fs_q_reg;
  wire fs_fall = bclk_rise & ~fs_s & fs_q_reg;

  // Control fields.
  wire offset_mode = tdm_reg[`BIT_OFFSET_MODE];
  wire alt_frame = tdm_reg[`BIT_ALT_FRAME];
  wire channel_swap = ctrl1_reg[`BIT_CHANNEL_SWAP];
  wire slot_enable = ctrl2_reg[`BIT_SLOT_ENABLE];
  wire pull_enable = ctrl2_reg[`BIT_PULL_ENABLE];
  wire pull_select = ctrl2_reg[`BIT_PULL_SELECT];
  wire tristate_ctl = ctrl2_reg[`BIT_TRISTATE_CTL];
  wire normal_audio = sense_reg[`BIT_NORMAL_AUDIO];
  wire sense_unsigned = sense_reg[`BIT_SENSE_UNSIGNED];
  wire gain_position = gain_ctl_reg[`BIT_GAIN_POSITION];
  wire [1:0] wlen_field = ctrl1_reg[`BIT_WLEN_HI:`BIT_WLEN_LO];
  word_len_t wlen;
  placement_t place;
  assign wlen = word_len_t'(wlen_field);
  // Offset mode takes precedence if software sets both placement bits.
  assign place = offset_mode ? PLACE_OFFSET : (slot_enable ? PLACE_SLOT : PLACE_PLAIN);

  // Word length in bits.
  wire [10:0] word_bits = (wlen == WLEN_16) ? 11'h010 :
                          (wlen == WLEN_20) ? 11'h014 :
                          (wlen == WLEN_24) ? 11'h018 : 11'h020;

  // Channel start positions in bit clocks after the frame sync.
  wire [10:0] left_delay_ext = 11'(left_delay_reg);
  wire [10:0] right_delay_ext = 11'(right_delay_reg);
  wire [10:0] left_start = (place == PLACE_PLAIN) ? 11'h000 : left_delay_ext;
  wire [10:0] right_start = (place == PLACE_SLOT) ? right_delay_ext :
                            11'(left_start + word_bits);
  wire [10:0] left_end = 11'(left_start + word_bits);
  wire [10:0] right_end = 11'(right_start + word_bits);
  wire in_left = (pos_reg >= left_start) && (pos_reg < left_end);
  wire in_right = (pos_reg >= right_start) && (pos_reg < right_end) && !in_left;
  wire [10:0] left_index = 11'(pos_reg - left_start);
  wire [10:0] right_index = 11'(pos_reg - right_start);

  // Converter message chosen by its type code.
  wire [7:0] message = (converter_type == `TYPE_JUNCTION) ? junction_temperature :
                       (converter_type == `TYPE_AMBIENT) ? ambient_temperature :
                       (converter_type == `TYPE_BATTERY) ? battery_voltage : 8'h00;

  // Sense words; unsigned format flips the sign bit.
  wire [15:0] v_data = {voltage_sense[15] ^ sense_unsigned, voltage_sense[14:0]};
  wire [15:0] i_data = {current_sense[15] ^ sense_unsigned, current_sense[14:0]};
  wire short_word = (wlen == WLEN_16);
  wire [7:0] v_tail = short_word ? 8'h00 : {`SENSE_PREAMBLE, converter_type};
  wire [7:0] i_tail = short_word ? 8'h00 : {message[7:4], message[3:0]};
  wire [31:0] v_word = {v_data, v_tail, 8'h00};
  wire [31:0] i_word = {i_data, i_tail, 8'h00};

  // Sense stereo needs normal audio and alternating frames both clear.
  wire sense_mode = !normal_audio && !alt_frame;
  wire [31:0] base_left = sense_mode ? v_word : audio_left;
  wire [31:0] base_right = sense_mode ? i_word : audio_right;
  wire [31:0] next_left = channel_swap ? base_right : base_left;
  wire [31:0] next_right = channel_swap ? base_left : base_right;

  // Bits for the coming rising edge, MSB first from the top of the word.
  wire left_bit = left_word_reg[5'd31 - left_index[4:0]];
  wire right_bit = right_word_reg[5'd31 - right_index[4:0]];

  // Idle output floats when tristate is asked for or pull enable and pull select are both clear.
  wire idle_release = tristate_ctl || (!pull_enable && !pull_select);

  // Gain exchange windows within the 16 bit clocks after frame sync falls.
  wire gain_first_half = !gcnt_reg[3];
  wire gain_tx = gact_reg && (gain_position ? gain_first_half : !gain_first_half);
  wire gain_rx = gact_reg && (gain_position ? !gain_first_half : gain_first_half);
  wire [7:0] grx_next = {grx_reg[6:0], gin_s};

  // Register decode.
  wire wr_tdm = reg_wr && (reg_addr == `ADDR_TDM_CTRL);
  wire wr_ctrl1 = reg_wr && (reg_addr == `ADDR_PORT_CTRL1);
  wire wr_ctrl2 = reg_wr && (reg_addr == `ADDR_PORT_CTRL2);
  wire wr_left = reg_wr && (reg_addr == `ADDR_LEFT_SLOT);
  wire wr_right = reg_wr && (reg_addr == `ADDR_RIGHT_SLOT);
  wire wr_sense = reg_wr && (reg_addr == `ADDR_SENSE_CTRL);
  wire wr_gain = reg_wr && (reg_addr == `ADDR_GAIN_CTRL);
  wire [15:0] rd_value =
    (reg_addr == `ADDR_TDM_CTRL) ? tdm_reg :
    (reg_addr == `ADDR_PORT_CTRL1) ? ctrl1_reg :
    (reg_addr == `ADDR_PORT_CTRL2) ? ctrl2_reg :
    (reg_addr == `ADDR_LEFT_SLOT) ? 16'(left_delay_reg) :
    (reg_addr == `ADDR_RIGHT_SLOT) ? 16'(right_delay_reg) :
    (reg_addr == `ADDR_RESULT_LOW) ? {ambient_temperature, junction_temperature} :
    (reg_addr == `ADDR_RESULT_HIGH) ? {8'h00, battery_voltage} :
    (reg_addr == `ADDR_SENSE_CTRL) ? sense_reg :
    (reg_addr == `ADDR_GAIN_CTRL) ? gain_ctl_reg :
    (reg_addr == `ADDR_GAIN_STATUS) ? {8'h00, partner_gain} : 16'h0000;

  // Software-written control registers.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdm_reg <= `RST_TDM_CTRL;
      ctrl1_reg <= `RST_PORT_CTRL1;
      ctrl2_reg <= `RST_PORT_CTRL2;
      sense_reg <= `RST_SENSE_CTRL;
      gain_ctl_reg <= `RST_GAIN_CTRL;
    end else begin
      if (wr_tdm) tdm_reg <= reg_wdata;
      if (wr_ctrl1) ctrl1_reg <= reg_wdata;
      if (wr_ctrl2) ctrl2_reg <= reg_wdata;
      if (wr_sense) sense_reg <= reg_wdata;
      if (wr_gain) gain_ctl_reg <= reg_wdata;
    end
  end

  // Slot delay fields.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_delay_reg <= DELAY_W'(`RST_SLOT_DELAY);
      right_delay_reg <= DELAY_W'(`RST_SLOT_DELAY);
    end else begin
      if (wr_left) left_delay_reg <= reg_wdata[DELAY_W-1:0];
      if (wr_right) right_delay_reg <= reg_wdata[DELAY_W-1:0];
    end
  end

  // Read data stands for exactly one cycle after the strobe.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_value : 16'h0000;
    end
  end

  // Pull requests follow the control bits.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_pull_up <= 1'b0;
      capture_pull_down <= 1'b0;
    end else begin
      capture_pull_up <= pull_enable && pull_select;
      capture_pull_down <= pull_enable && !pull_select;
    end
  end

  // Edge history and the frame bit position, counted on rising edges.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_d_reg <= 1'b0;
      fs_q_reg <= 1'b0;
      pos_reg <= `POS_IDLE;
    end else begin
      bclk_d_reg <= bclk_s;
      if (bclk_rise) begin
        fs_q_reg <= fs_s;
        if (fs_rise) begin
          pos_reg <= 11'h000;
        end else if (pos_reg != `POS_IDLE) begin
          pos_reg <= 11'(pos_reg + 11'h001);
        end
      end
    end
  end

  // Channel words are frozen at frame start so a frame never tears.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_word_reg <= 32'h0000_0000;
      right_word_reg <= 32'h0000_0000;
    end else if (fs_rise) begin
      left_word_reg <= next_left;
      right_word_reg <= next_right;
    end
  end

  // Capture output changes on falling edges so the host samples on rising ones.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_serial_out <= 1'b0;
      capture_serial_oe <= 1'b0;
      last_bit_reg <= 1'b0;
    end else if (bclk_fall) begin
      if (in_left) begin
        capture_serial_out <= left_bit;
        capture_serial_oe <= 1'b1;
        last_bit_reg <= left_bit;
      end else if (in_right) begin
        capture_serial_out <= right_bit;
        capture_serial_oe <= 1'b1;
        last_bit_reg <= right_bit;
      end else begin
        capture_serial_out <= last_bit_reg;
        capture_serial_oe <= !idle_release;
      end
    end
  end

  // Playback data is sampled on rising edges inside the left slot.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pb_shift_reg <= 32'h0000_0000;
      playback_word <= 32'h0000_0000;
    end else if (bclk_rise) begin
      if (fs_rise) begin
        pb_shift_reg <= 32'h0000_0000;
      end else if (in_left) begin
        pb_shift_reg <= {pb_shift_reg[30:0], pb_s};
        if (pos_reg == 11'(left_end - 11'h001)) begin
          playback_word <= {pb_shift_reg[30:0], pb_s};
        end
      end
    end
  end

  // Gain exchange counter and receiver, started by the frame sync falling edge.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gcnt_reg <= 4'h0;
      gact_reg <= 1'b0;
      grx_reg <= 8'h00;
      partner_gain <= 8'h00;
    end else if (bclk_rise) begin
      if (fs_fall) begin
        gcnt_reg <= 4'h0;
        gact_reg <= 1'b1;
      end else if (gact_reg) begin
        if (gain_rx) begin
          grx_reg <= grx_next;
          if (gcnt_reg[2:0] == 3'h7) begin
            partner_gain <= grx_next;
          end
        end
        if (gcnt_reg == 4'hF) begin
          gact_reg <= 1'b0;
        end
        gcnt_reg <= 4'(gcnt_reg + 4'h1);
      end
    end
  end

  // Gain pin is driven only during the send window, changing on falling edges.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_share_pin_out <= 1'b0;
      gain_share_pin_oe <= 1'b0;
    end else if (bclk_fall) begin
      if (gain_tx) begin
        gain_share_pin_out <= own_gain[3'h7 - gcnt_reg[2:0]];
        gain_share_pin_oe <= 1'b1;
      end else begin
        gain_share_pin_out <= 1'b0;
        gain_share_pin_oe <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// >>> audio_port_host.sv
/* Host side of the serial port: bit clock, frame sync, playback bits and gain pin.
   Assumes the bench calls run_frame between register updates. */
`timescale 1ns/1ns
`default_nettype none
module audio_port_host (
  input wire logic core_clk, // Paces the floating pattern.
  input wire logic dev_pos, // Gain share position of the device.
  input wire logic [7:0] host_gain, // Gain byte sent by this side.
  input wire logic [95:0] pb_vec, // Playback bit for each position.
  input wire logic cap_out, // Device serial output value.
  input wire logic cap_oe, // Device serial output enable.
  input wire logic pull_up, // Device pull-up request.
  input wire logic pull_down, // Device pull-down request.
  input wire logic g_out, // Device gain pin value.
  input wire logic g_oe, // Device gain pin enable.
  output var logic bclk, // Bit clock, still outside frames.
  output var logic fs, // Frame sync.
  output var logic pb_in, // Playback serial data.
  output logic g_in // Gain pin wire level.
);
  logic c_last = 1'b0;
  logic g_last = 1'b0;
  logic h_oe, h_val;
  logic cap_bit [80];
  logic cap_oe_s [80];
  logic [7:0] rx_gain;
  wire logic cap_wire;
  // Undriven wires without a pull show a pattern that changes every cycle.
  assign cap_wire = cap_oe ? cap_out : pull_up ? 1'b1 : pull_down ? 1'b0 : ~c_last;
  assign g_in = g_oe ? g_out : h_oe ? h_val : ~g_last;
  always @(posedge core_clk) begin
    c_last <= cap_wire;
    g_last <= g_in;
  end
  initial begin
    {bclk, fs, pb_in, h_oe, h_val} = 5'h00;
  end
  // One frame: edge 1 carries the sync pulse, position p sits at edge p+2.
  task automatic run_frame();
    int k, p, g;
    for (k = 0; k < 98; k++) begin
      p = k - 2;
      g = k - 3;
      fs = (k == 1);
      pb_in = (p >= 0) ? pb_vec[p] : 1'b0;
      h_oe = (g >= 0) && (g < 16) && ((g >= 8) == dev_pos);
      h_val = host_gain[3'(7 - g)];
      #63 bclk = 1'b1;
      if (p >= 0 && p < 80) begin
        cap_bit[p] = cap_wire;
        cap_oe_s[p] = cap_oe;
      end
      if (g >= 0 && g < 16 && ((g >= 8) != dev_pos)) rx_gain[3'(7 - g)] = g_in;
      #62 bclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> audio_port_framing_props.sv
/* Port checker for the framing block.
   Assumes bclk stays low between frames and inputs are steady during reads. */
`timescale 1ns/1ns
`default_nettype none
`include "audio_port_cfg.svh"
module audio_port_framing_props (
  input wire logic core_clk, // Core clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [15:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [15:0] reg_rdata, // Read data.
  input wire logic bclk_pin, // Bit clock.
  input wire logic capture_serial_out, // Serial output.
  input wire logic capture_serial_oe, // Serial output enable.
  input wire logic capture_pull_up, // Pull-up request.
  input wire logic capture_pull_down, // Pull-down request.
  input wire logic gain_share_pin_out, // Gain pin value.
  input wire logic gain_share_pin_oe, // Gain pin enable.
  input wire logic [7:0] ambient_temperature, // Result 1.
  input wire logic [7:0] junction_temperature, // Result 0.
  input wire logic [7:0] battery_voltage, // Result 2.
  input wire logic [7:0] partner_gain, // Received gain.
  input wire logic [31:0] playback_word // Playback word.
);
  logic [7:0] quiet_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Counts core cycles with the bit clock low, saturating.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) quiet_cnt <= 8'h00;
    else if (bclk_pin) quiet_cnt <= 8'h00;
    else if (quiet_cnt != 8'hFF) quiet_cnt <= quiet_cnt + 8'h01;
  end
  pull_map_a: assert property ($past(reg_wr, 2) && $past(reg_addr, 2) == `ADDR_PORT_CTRL2 |->
    capture_pull_up == ($past(reg_wdata[6], 2) & $past(reg_wdata[5], 2)) &&
    capture_pull_down == ($past(reg_wdata[6], 2) & ~$past(reg_wdata[5], 2))) else $error("pull map");
  result_low_a: assert property (reg_rd && reg_addr == `ADDR_RESULT_LOW |=>
    reg_rdata == {$past(ambient_temperature), $past(junction_temperature)}) else $error("result low");
  result_high_a: assert property (reg_rd && reg_addr == `ADDR_RESULT_HIGH |=>
    reg_rdata == {8'h00, $past(battery_voltage)}) else $error("result high");
  oe_edge_a: assert property ($changed(capture_serial_oe) |->
    !bclk_pin && !$past(bclk_pin) && !$past(bclk_pin, 2)) else $error("oe off falling edge");
  data_edge_a: assert property ($changed(capture_serial_out) |->
    !bclk_pin && !$past(bclk_pin) && !$past(bclk_pin, 2)) else $error("data off falling edge");
  gain_edge_a: assert property ($changed(gain_share_pin_out) || $changed(gain_share_pin_oe) |->
    !bclk_pin && !$past(bclk_pin) && !$past(bclk_pin, 2)) else $error("gain pin off falling edge");
  gain_rx_a: assert property ($changed(partner_gain) |->
    bclk_pin && $past(bclk_pin, 2)) else $error("gain taken off rising edge");
  playback_edge_a: assert property ($changed(playback_word) |->
    bclk_pin && $past(bclk_pin, 2)) else $error("playback off rising edge");
  idle_float_a: assert property (quiet_cnt > 8'h28 && !capture_pull_up && !capture_pull_down |->
    !capture_serial_oe) else $error("idle output driven");
endmodule
bind audio_port_framing audio_port_framing_props props_u (.core_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bclk_pin, .capture_serial_out, .capture_serial_oe,
  .capture_pull_up, .capture_pull_down, .gain_share_pin_out, .gain_share_pin_oe,
  .ambient_temperature, .junction_temperature, .battery_voltage, .partner_gain, .playback_word);
`default_nettype wire

// >>> test_audio_port_framing.sv
/* Self-checking bench for the framing block with a host model.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ns
`default_nettype none
`include "audio_port_cfg.svh"
module test_audio_port_framing;
  import audio_port_pkg::*;
  logic core_clk, rst_n, reg_wr, reg_rd, dev_pos;
  logic [7:0] reg_addr, tj, ta, vb, og, hg, msg;
  logic [15:0] reg_wdata, vs, cs;
  logic [3:0] ty;
  logic [31:0] al, ar, lw, rw, ew;
  logic [95:0] pbv;
  logic eo, eb;
  wire logic [15:0] reg_rdata;
  wire logic [7:0] pg;
  wire logic [31:0] pw;
  wire logic bclk, fs, pb_in, c_out, c_oe, pu, pd, g_in, g_out, g_oe;
  int errors = 0, n_tests = 0, seed = 11626, i, j, p, c, nb, ls, rs;
  // Register order: 0C, 0D, 0E, 0F, 10, 28, 30, then the type code.
  localparam logic [7:0] ADDRS [7] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h28, 8'h30};
  localparam logic [15:0] CFG [7][8] = '{
    '{16'h0000, 16'h0000, 16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000},
    '{16'h0000, 16'h0028, 16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000},
    '{16'h0000, 16'h000C, 16'h0050, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001},
    '{16'h0000, 16'h000C, 16'h0400, 16'h0005, 16'h0032, 16'h0000, 16'h0001, 16'h0003},
    '{16'h4100, 16'h0008, 16'h0440, 16'h0003, 16'h0040, 16'h0000, 16'h0000, 16'h0002},
    '{16'h0000, 16'h0004, 16'h0060, 16'h0000, 16'h0000, 16'h8000, 16'h0001, 16'h0001},
    '{16'h0000, 16'h000C, 16'h0060, 16'h0002, 16'h0000, 16'h0080, 16'h0000, 16'h0002}};
  audio_port_framing dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bclk_pin(bclk), .fs_pin(fs), .playback_serial_in(pb_in), .capture_serial_out(c_out),
    .capture_serial_oe(c_oe), .capture_pull_up(pu), .capture_pull_down(pd),
    .gain_share_pin_in(g_in), .gain_share_pin_out(g_out), .gain_share_pin_oe(g_oe),
    .audio_left(al), .audio_right(ar), .voltage_sense(vs), .current_sense(cs),
    .converter_type(ty), .junction_temperature(tj), .ambient_temperature(ta),
    .battery_voltage(vb), .own_gain(og), .partner_gain(pg), .playback_word(pw));
  audio_port_host host_u (.core_clk(core_clk), .dev_pos(dev_pos), .host_gain(hg), .pb_vec(pbv),
    .cap_out(c_out), .cap_oe(c_oe), .pull_up(pu), .pull_down(pd), .g_out(g_out), .g_oe(g_oe),
    .bclk(bclk), .fs(fs), .pb_in(pb_in), .g_in(g_in));
  // Core clock, 8 ns period.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(32'(reg_rdata), 32'(exp), "register read");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog sized well beyond seven frames and the register traffic.
  initial begin
    #500000;
    errors++;
    final_report();
  end
  // Main sequence: one frame per configuration row, checked against the model.
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, dev_pos, hg, pbv} = '0;
    {al, ar, vs, cs, ty, tj, ta, vb, og} = '0;
    eb = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(`ADDR_PORT_CTRL2, 16'h0040);
    chk(32'(pd), 32'h1, "reset pull");
    for (i = 0; i < 7; i++) begin
      for (j = 0; j < 7; j++) wr(ADDRS[j], CFG[i][j]);
      @(posedge core_clk);
      {al, ar, vs, cs, tj, ta, vb, og, hg} <= 136'({$random(seed), $random(seed),
        $random(seed), $random(seed), $random(seed)});
      pbv <= {$random(seed), $random(seed), $random(seed)};
      ty <= CFG[i][7][3:0];
      dev_pos <= CFG[i][6][0];
      repeat (2) @(posedge core_clk);
      host_u.run_frame();
      repeat (8) @(posedge core_clk);
      c = int'(CFG[i][1][3:2]);
      nb = (c == 3) ? 32 : 16 + 4 * c;
      msg = (ty == 4'h0) ? tj : (ty == 4'h1) ? ta : (ty == 4'h3) ? vb : 8'h00;
      lw = {vs ^ {CFG[i][5][7], 15'h0000}, 4'hA, ty, 8'h00};
      rw = {cs ^ {CFG[i][5][7], 15'h0000}, msg, 8'h00};
      if (CFG[i][5][15] || CFG[i][0][8]) {lw, rw} = {al, ar};
      if (CFG[i][1][5]) {lw, rw} = {rw, lw};
      ls = (CFG[i][0][14] || CFG[i][2][10]) ? int'(CFG[i][3][9:0]) : 0;
      rs = CFG[i][0][14] ? ls + nb : CFG[i][2][10] ? int'(CFG[i][4][9:0]) : nb;
      for (p = 0; p < 80; p++) begin
        if (p >= ls && p < ls + nb) {eo, eb} = {1'b1, lw[31 - (p - ls)]};
        else if (p >= rs && p < rs + nb) {eo, eb} = {1'b1, rw[31 - (p - rs)]};
        else eo = !(CFG[i][2][4] || (!CFG[i][2][6] && !CFG[i][2][5]));
        chk(32'(host_u.cap_oe_s[p]), 32'(eo), "output enable");
        if (eo) chk(32'(host_u.cap_bit[p]), 32'(eb), "output bit");
      end
      ew = '0;
      for (p = ls; p < ls + nb; p++) ew = {ew[30:0], pbv[p]};
      chk(pw, ew, "playback word");
      chk(32'(pg), 32'(hg), "partner gain");
      chk(32'(host_u.rx_gain), 32'(og), "sent gain");
      chk(32'({pu, pd}), 32'({CFG[i][2][6] & CFG[i][2][5], CFG[i][2][6] & ~CFG[i][2][5]}), "pulls");
      rd(`ADDR_RESULT_LOW, {ta, tj});
      rd(`ADDR_RESULT_HIGH, {8'h00, vb});
      rd(`ADDR_GAIN_STATUS, {8'h00, hg});
      $display("test %0d finished", i);
    end
    wr(`ADDR_LEFT_SLOT, 16'hFFFF);
    rd(`ADDR_LEFT_SLOT, 16'h03FF);
    wr(`ADDR_RESULT_HIGH, 16'h5A5A);
    rd(`ADDR_RESULT_HIGH, {8'h00, vb});
    rd(8'h55, 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
